// >>> logic/emp_pin_ctrl.sv
//
// Overview of operation
// R01: DRAM row then column on eleven lines
// R02: SRAM drives address bits 0-14 directly
// R03: Bit 15 pin: address or select four
// R04: Bit 16 pin: address, select three, column strobe
// R05: Bit 17 pin: address, select two, row strobe
// R06: Dedicated select one for its region
// R07: Write strobe low only while writing
// R08: Read strobe low only while reading
// R09: Data bus driven only during writes
// R10: Nibble mode leaves upper data lines undriven
// R11: Resets and stop keep selects, strobes high
// R12: Address holds; software reset raises bits 15-17
// R13: Individual reset with refresh drives strobes low
//
`timescale 1ns/100ps
`default_nettype none

module emp_pin_ctrl
    import emp_pkg::*;
#(
    parameter int ADDR_W = REQ_ADDR_W
)
(
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  sw_reset,
    input  wire logic                  indiv_reset,
    input  wire logic                  stop_mode,
    input  wire logic                  cfg_nibble_bus,
    input  wire logic                  cfg_dram_en,
    input  wire logic                  cfg_refresh_en,
    input  wire logic                  cfg_select_four_en,
    input  wire logic                  cfg_select_three_en,
    input  wire logic                  cfg_select_two_en,
    input  wire logic                  req_valid,
    output logic                       req_ready,
    input  wire logic                  req_write,
    input  wire logic                  req_dram,
    input  wire logic [1:0]            req_select,
    input  wire logic [ADDR_W-1:0]     req_addr,
    input  wire logic [DATA_W-1:0]     req_wdata,
    output logic                       rsp_valid,
    output logic      [DATA_W-1:0]     rsp_rdata,
    output logic      [LOW_ADDR_W-1:0] mem_addr_low_bus,
    output logic                       mem_addr_bit15_out,
    output logic                       mem_addr_bit16_out,
    output logic                       mem_addr_bit17_out,
    output logic                       sram_select_one_n,
    output logic                       mem_write_strobe_n,
    output logic                       mem_read_strobe_n,
    input  wire logic [DATA_W-1:0]     mem_data_bus_in,
    output logic      [DATA_W-1:0]     mem_data_bus_out,
    output logic      [DATA_W-1:0]     mem_data_bus_oe
);

    emp_state_e          state;
    emp_state_e          next_state;
    logic                cur_write;
    logic                cur_dram;
    logic [1:0]          cur_select;
    logic [ADDR_W-1:0]   cur_addr;
    logic [2:0]          count;
    logic [DATA_W-1:0]   data_sync;
    logic                any_hold;
    logic                accept;
    logic                last_beat;
    logic                next_write;
    logic                next_dram;
    logic [1:0]          next_select;
    logic [ADDR_W-1:0]   next_addr;
    logic                next_in_access;
    logic [LOW_ADDR_W-1:0] next_addr_low;
    logic                next_bit15;
    logic                next_bit16;
    logic                next_bit17;
    logic                next_sel_one_n;
    logic                next_wr_n;
    logic                next_rd_n;

    localparam logic [2:0] LAST_COUNT = 3'(ACTIVE_CYCLES - 1);

    assign any_hold  = sw_reset | indiv_reset | stop_mode;
    assign req_ready = (state == EMP_IDLE) && !any_hold;
    assign accept    = req_valid && req_ready;
    assign last_beat = (state == EMP_ACTIVE) && (count == LAST_COUNT);
    assign rsp_valid = (state == EMP_RECOVER);

    // ------------------------------------------------------------
    // Data pin synchroniser
    // ------------------------------------------------------------
    emp_sync #(
        .WIDTH (DATA_W)
    ) u_data_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (mem_data_bus_in),
        .sync_out (data_sync)
    );

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            EMP_IDLE:       if (accept) next_state = EMP_SETUP;
            EMP_SETUP:      next_state = cur_dram ? EMP_ROW_STROBE : EMP_ACTIVE;
            EMP_ROW_STROBE: next_state = EMP_ACTIVE;
            EMP_ACTIVE:     if (count == LAST_COUNT) next_state = EMP_RECOVER;
            EMP_RECOVER:    next_state = EMP_IDLE;
            default:        next_state = EMP_IDLE;
        endcase
        if (any_hold)
            next_state = EMP_IDLE;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            state <= EMP_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge clock)
    begin
        if (rst || state != EMP_ACTIVE)
            count <= '0;
        else
            count <= count + 3'h1;
    end

    assign next_write  = accept ? req_write  : cur_write;
    assign next_dram   = accept ? req_dram   : cur_dram;
    assign next_select = accept ? req_select : cur_select;
    assign next_addr   = accept ? req_addr   : cur_addr;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cur_write  <= 1'b0;
            cur_dram   <= 1'b0;
            cur_select <= SEL_ONE;
            cur_addr   <= '0;
        end
        else
        begin
            cur_write  <= next_write;
            cur_dram   <= next_dram;
            cur_select <= next_select;
            cur_addr   <= next_addr;
        end
    end

    // ------------------------------------------------------------
    // Pin values for the coming state
    // ------------------------------------------------------------
    always_comb
    begin
        next_in_access = (next_state == EMP_SETUP) || (next_state == EMP_ROW_STROBE) || (next_state == EMP_ACTIVE);
        next_addr_low  = mem_addr_low_bus;
        next_bit15     = mem_addr_bit15_out;
        next_bit16     = mem_addr_bit16_out;
        next_bit17     = mem_addr_bit17_out;
        next_sel_one_n = PIN_IDLE;
        next_wr_n      = !(next_state == EMP_ACTIVE && next_write);            // [R07]
        next_rd_n      = !(next_state == EMP_ACTIVE && !next_write);           // [R08]
        if (next_state == EMP_IDLE)
        begin
            if (cfg_select_four_en)
                next_bit15 = PIN_IDLE;
            if (cfg_dram_en || cfg_select_three_en)
                next_bit16 = PIN_IDLE;
            if (cfg_dram_en || cfg_select_two_en)
                next_bit17 = PIN_IDLE;
        end
        else if (next_dram)
        begin
            if (next_state == EMP_SETUP || next_state == EMP_ROW_STROBE)
                next_addr_low = LOW_ADDR_W'(next_addr[ROW_LSB +: DRAM_ADDR_W]);  // [R01]
            else
                next_addr_low = LOW_ADDR_W'(next_addr[DRAM_ADDR_W-1:0]);         // [R01]
            next_bit16 = !(next_state == EMP_ACTIVE);                              // [R04]
            next_bit17 = !(next_state == EMP_ROW_STROBE || next_state == EMP_ACTIVE); // [R05]
        end
        else
        begin
            next_addr_low  = next_addr[LOW_ADDR_W-1:0];                                       // [R02]
            next_bit15     = cfg_select_four_en ? !(next_in_access && next_select == SEL_FOUR)
                                                : next_addr[ADDR_BIT15];                      // [R03]
            next_bit16     = cfg_select_three_en ? !(next_in_access && next_select == SEL_THREE)
                                                 : next_addr[ADDR_BIT16];                     // [R04]
            next_bit17     = cfg_select_two_en ? !(next_in_access && next_select == SEL_TWO)
                                               : next_addr[ADDR_BIT17];                       // [R05]
            next_sel_one_n = !(next_in_access && next_select == SEL_ONE);                     // [R06]
        end
    end

    // ------------------------------------------------------------
    // Address pins with reset and stop overlay
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mem_addr_low_bus   <= ADDR_LOW_RESET;                          // [R11]
            mem_addr_bit15_out <= PIN_IDLE;
            mem_addr_bit16_out <= PIN_IDLE;
            mem_addr_bit17_out <= PIN_IDLE;
        end
        else if (sw_reset)
        begin
            mem_addr_bit15_out <= PIN_IDLE;                                // [R12]
            mem_addr_bit16_out <= PIN_IDLE;                                // [R12]
            mem_addr_bit17_out <= PIN_IDLE;
        end
        else if (indiv_reset || stop_mode)
        begin
            // Strobe pins follow the refresh rule, address pins hold
            if (cfg_dram_en)
            begin
                mem_addr_bit16_out <= !(indiv_reset && cfg_refresh_en);    // [R13]
                mem_addr_bit17_out <= !(indiv_reset && cfg_refresh_en);    // [R13]
            end
            else
            begin
                if (cfg_select_three_en)
                    mem_addr_bit16_out <= PIN_IDLE;                        // [R11]
                if (cfg_select_two_en)
                    mem_addr_bit17_out <= PIN_IDLE;
            end
            if (cfg_select_four_en)
                mem_addr_bit15_out <= PIN_IDLE;
        end
        else
        begin
            mem_addr_low_bus   <= next_addr_low;
            mem_addr_bit15_out <= next_bit15;
            mem_addr_bit16_out <= next_bit16;
            mem_addr_bit17_out <= next_bit17;
        end
    end

    // ------------------------------------------------------------
    // Select and strobe pins
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst || any_hold)
        begin
            sram_select_one_n  <= PIN_IDLE;                                // [R11]
            mem_write_strobe_n <= PIN_IDLE;
            mem_read_strobe_n  <= PIN_IDLE;
        end
        else
        begin
            sram_select_one_n  <= next_sel_one_n;
            mem_write_strobe_n <= next_wr_n;
            mem_read_strobe_n  <= next_rd_n;
        end
    end

    // ------------------------------------------------------------
    // Data bus
    // ------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (rst || any_hold)
            mem_data_bus_oe <= '0;                                         // [R09]
        else if (next_write && next_in_access)
            mem_data_bus_oe <= cfg_nibble_bus ? DATA_W'({NIBBLE_W{1'b1}}) : '1; // [R10]
        else
            mem_data_bus_oe <= '0;                                         // [R09]
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            mem_data_bus_out <= '0;
        else if (accept)
            mem_data_bus_out <= req_wdata;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            rsp_rdata <= '0;
        else if (last_beat && !cur_write)
            rsp_rdata <= cfg_nibble_bus ? (data_sync & DATA_W'({NIBBLE_W{1'b1}})) : data_sync; // [R10]
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_hw_reset_pins;
        @(posedge clock) disable iff (1'b0)
        rst |=> (&mem_addr_low_bus) && mem_addr_bit15_out && mem_addr_bit16_out && mem_addr_bit17_out
                && sram_select_one_n && mem_write_strobe_n && mem_read_strobe_n && (mem_data_bus_oe == '0);
    endproperty
    a_hw_reset_pins: assert property (p_hw_reset_pins) else $error("pins not high after reset"); // [R11]

    property p_hold_selects;
        @(posedge clock) disable iff (rst)
        any_hold |-> !req_ready ##1 (sram_select_one_n && mem_write_strobe_n && mem_read_strobe_n);
    endproperty
    a_hold_selects: assert property (p_hold_selects) else $error("select or strobe low in hold"); // [R11]

    property p_sw_reset_addr;
        @(posedge clock) disable iff (rst)
        sw_reset |=> $stable(mem_addr_low_bus) && mem_addr_bit15_out && mem_addr_bit16_out && mem_addr_bit17_out;
    endproperty
    a_sw_reset_addr: assert property (p_sw_reset_addr) else $error("software reset address pins wrong"); // [R12]

    property p_indiv_refresh;
        @(posedge clock) disable iff (rst)
        (indiv_reset && !sw_reset && cfg_dram_en && cfg_refresh_en)
            |=> !mem_addr_bit16_out && !mem_addr_bit17_out && $stable(mem_addr_low_bus);
    endproperty
    a_indiv_refresh: assert property (p_indiv_refresh) else $error("refresh strobes not low"); // [R13]

    property p_dram_sequence;
        @(posedge clock) disable iff (rst || any_hold)
        (state == EMP_SETUP && cur_dram)
            |-> mem_addr_bit17_out ##1 (!mem_addr_bit17_out && mem_addr_bit16_out
                && mem_addr_low_bus == LOW_ADDR_W'(cur_addr[ROW_LSB +: DRAM_ADDR_W]))
            ##1 (!mem_addr_bit16_out && mem_addr_low_bus == LOW_ADDR_W'(cur_addr[DRAM_ADDR_W-1:0]));
    endproperty
    a_dram_sequence: assert property (p_dram_sequence) else $error("row column sequence wrong"); // [R01]

    property p_sram_addr;
        @(posedge clock) disable iff (rst)
        (state == EMP_ACTIVE && !cur_dram) |-> mem_addr_low_bus == cur_addr[LOW_ADDR_W-1:0];
    endproperty
    a_sram_addr: assert property (p_sram_addr) else $error("static address pins wrong"); // [R02]

    property p_select_four;
        @(posedge clock) disable iff (rst)
        (state == EMP_ACTIVE && !cur_dram && cfg_select_four_en)
            |-> mem_addr_bit15_out == (cur_select != SEL_FOUR);
    endproperty
    a_select_four: assert property (p_select_four) else $error("select four pin wrong"); // [R03]

    property p_select_one;
        @(posedge clock) disable iff (rst)
        !sram_select_one_n |-> !cur_dram && cur_select == SEL_ONE && state != EMP_IDLE;
    endproperty
    a_select_one: assert property (p_select_one) else $error("select one asserted wrongly"); // [R06]

    property p_write_strobe;
        @(posedge clock) disable iff (rst)
        !mem_write_strobe_n |-> cur_write && mem_read_strobe_n && state == EMP_ACTIVE && mem_data_bus_oe != '0;
    endproperty
    a_write_strobe: assert property (p_write_strobe) else $error("write strobe without write"); // [R07]

    property p_read_strobe;
        @(posedge clock) disable iff (rst)
        !mem_read_strobe_n |-> !cur_write && state == EMP_ACTIVE && mem_data_bus_oe == '0;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("read strobe without read"); // [R08]

    property p_bus_idle;
        @(posedge clock) disable iff (rst)
        (state == EMP_IDLE || state == EMP_RECOVER) |-> mem_data_bus_oe == '0;
    endproperty
    a_bus_idle: assert property (p_bus_idle) else $error("data bus driven while idle"); // [R09]

    property p_nibble_bus;
        @(posedge clock) disable iff (rst)
        $past(cfg_nibble_bus) |-> mem_data_bus_oe[DATA_W-1:NIBBLE_W] == '0;
    endproperty
    a_nibble_bus: assert property (p_nibble_bus) else $error("upper data lines driven"); // [R10]

endmodule

`default_nettype wire

// >>> logic/emp_pkg.sv
package emp_pkg;

    // Pin field layout
    localparam int DATA_W         = 8;
    localparam int NIBBLE_W       = 4;
    localparam int LOW_ADDR_W     = 15;
    localparam int DRAM_ADDR_W    = 11;
    localparam int ROW_LSB        = 11;
    localparam int ADDR_BIT15     = 15;
    localparam int ADDR_BIT16     = 16;
    localparam int ADDR_BIT17     = 17;
    localparam int REQ_ADDR_W     = 22;

    // Select codes carried with a static memory request
    localparam logic [1:0] SEL_ONE   = 2'h0;
    localparam logic [1:0] SEL_TWO   = 2'h1;
    localparam logic [1:0] SEL_THREE = 2'h2;
    localparam logic [1:0] SEL_FOUR  = 2'h3;

    // Timing counts in clock cycles
    localparam int ACTIVE_CYCLES  = 4;
    localparam int SYNC_STAGES    = 2;

    // Reset values
    localparam logic [LOW_ADDR_W-1:0] ADDR_LOW_RESET = 15'h7FFF;
    localparam logic                  PIN_IDLE       = 1'b1;

    typedef enum logic [2:0] {
        EMP_IDLE,
        EMP_SETUP,
        EMP_ROW_STROBE,
        EMP_ACTIVE,
        EMP_RECOVER
    } emp_state_e;

endpackage

// >>> logic/emp_sync.sv
`timescale 1ns/100ps
`default_nettype none

module emp_sync
    import emp_pkg::*;
#(
    parameter int WIDTH = DATA_W
)
(
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            stage_one <= '0;
            sync_out  <= '0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end

endmodule

`default_nettype wire

// >>> verification/emp_mem_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// External memory parts on the shared pins
// ----------------------------------------
module emp_mem_model
    import emp_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  cfg_dram_en,
    input  wire logic [LOW_ADDR_W-1:0] mem_addr_low_bus,
    input  wire logic                  mem_addr_bit15_out,
    input  wire logic                  mem_addr_bit16_out,
    input  wire logic                  mem_addr_bit17_out,
    input  wire logic                  mem_write_strobe_n,
    input  wire logic                  mem_read_strobe_n,
    input  wire logic [DATA_W-1:0]     mem_data_bus_in,
    output logic                       m_en,
    output logic      [DATA_W-1:0]     m_val
);
    logic [DATA_W-1:0] mem [int];
    logic [10:0]       row;
    int                key;

    // Row taken as the row strobe falls
    always @(negedge mem_addr_bit17_out)
        if (cfg_dram_en)
            row = mem_addr_low_bus[10:0];

    // Dynamic cell while row strobe low, else static place
    always @*
    begin
        if (cfg_dram_en && !mem_addr_bit17_out)
            key = int'({1'b1, row, mem_addr_low_bus[10:0]});
        else
            key = int'({mem_addr_bit17_out, mem_addr_bit16_out, mem_addr_bit15_out, mem_addr_low_bus});
        m_en = !mem_read_strobe_n;
        m_val = mem.exists(key) ? mem[key] : 8'hA5;
    end

    always @(posedge clock)
        if (!mem_write_strobe_n)
            mem[key] = mem_data_bus_in;
endmodule

`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench
    import emp_pkg::*;
;
    logic        clock, rst, sw_reset, indiv_reset, stop_mode, cfg_nibble_bus, cfg_dram_en, cfg_refresh_en;
    logic        cfg_select_four_en, cfg_select_three_en, cfg_select_two_en, req_valid, req_ready;
    logic        req_write, req_dram, rsp_valid, sram_select_one_n, m_en;
    logic        mem_addr_bit15_out, mem_addr_bit16_out, mem_addr_bit17_out, mem_write_strobe_n, mem_read_strobe_n;
    logic [1:0]  req_select;
    logic [21:0] req_addr;
    logic [7:0]  req_wdata, rsp_rdata, mem_data_bus_in, mem_data_bus_out, mem_data_bus_oe, m_val, float_bus;
    logic [14:0] mem_addr_low_bus;
    logic [14:0] s_low [10];
    logic [5:0]  s_pin [10];
    logic [7:0]  s_oe  [10];
    int          lat, bad_count, checks;

    emp_pin_ctrl dut (.clock, .rst, .sw_reset, .indiv_reset, .stop_mode, .cfg_nibble_bus, .cfg_dram_en,
        .cfg_refresh_en, .cfg_select_four_en, .cfg_select_three_en, .cfg_select_two_en, .req_valid,
        .req_ready, .req_write, .req_dram, .req_select, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
        .mem_addr_low_bus, .mem_addr_bit15_out, .mem_addr_bit16_out, .mem_addr_bit17_out,
        .sram_select_one_n, .mem_write_strobe_n, .mem_read_strobe_n, .mem_data_bus_in,
        .mem_data_bus_out, .mem_data_bus_oe);

    emp_mem_model memory (.clock, .cfg_dram_en, .mem_addr_low_bus, .mem_addr_bit15_out, .mem_addr_bit16_out,
        .mem_addr_bit17_out, .mem_write_strobe_n, .mem_read_strobe_n, .mem_data_bus_in, .m_en, .m_val);

    // ----------------------------------------
    // Clock and data pin level
    // ----------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Nobody driving: no pull-ups, level wanders
    always @(posedge clock)
        float_bus <= ~mem_data_bus_in;
    assign mem_data_bus_in = (mem_data_bus_oe & mem_data_bus_out) | (~mem_data_bus_oe & (m_en ? m_val : float_bus));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    function automatic logic [5:0] pins();
        return {mem_addr_bit15_out, mem_addr_bit16_out, mem_addr_bit17_out,
                sram_select_one_n, mem_write_strobe_n, mem_read_strobe_n};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tick();
        @(posedge clock);
        #2;
    endtask

    // One request, pins recorded from the accept cycle on
    task automatic access(input logic wr, input logic dram, input logic [1:0] sel,
                          input logic [21:0] addr, input logic [7:0] wd, input int abort_at);
        int n;
        n = 0;
        while (req_ready !== 1'b1)
        begin
            tick();
            n++;
            if (n > 50)
            begin
                bad_count++;
                complete_run();
            end
        end
        req_valid = 1'b1;
        req_write = wr;
        req_dram = dram;
        req_select = sel;
        req_addr = addr;
        req_wdata = wd;
        lat = 0;
        for (int k = 0; k < 10; k++)
        begin
            s_low[k] = mem_addr_low_bus;
            s_pin[k] = pins();
            s_oe[k] = mem_data_bus_oe;
            if (rsp_valid === 1'b1 && lat == 0)
                lat = k;
            if (k == abort_at)
                sw_reset = 1'b1;
            tick();
            if (k == 0)
                req_valid = 1'b0;
        end
        sw_reset = 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_static();
        access(1'b1, 1'b0, SEL_ONE, 22'h02D5A3, 8'h3C, 99);
        check("write latency", 6, lat);
        check("static address", 15'h55A3, s_low[3]);
        check("write pins", 6'b101001, s_pin[3]);
        check("write drive", 8'hFF, s_oe[3]);
        check("idle pins", 6'b101111, s_pin[9]);
        check("idle drive", 8'h00, s_oe[9]);
        access(1'b0, 1'b0, SEL_ONE, 22'h02D5A3, 8'h00, 99);
        check("read latency", 6, lat);
        check("read pins", 6'b101010, s_pin[3]);
        check("read drive", 8'h00, s_oe[3]);
        check("read data", 8'h3C, rsp_rdata);
    endtask

    task automatic t_selects();
        logic [1:0] s;
        {cfg_select_four_en, cfg_select_three_en, cfg_select_two_en} = 3'b111;
        for (int i = 0; i < 4; i++)
        begin
            s = 2'(i);
            access(1'b1, 1'b0, s, 22'h02D5A3, 8'h40 + 8'(i), 99);
            check("select pins", {s != 2'h3, s != 2'h2, s != 2'h1, s != 2'h0, 2'b01}, s_pin[3]);
            check("select idle", 6'h3F, s_pin[9]);
            access(1'b0, 1'b0, s, 22'h02D5A3, 8'h00, 99);
            check("select read data", 8'h40 + 8'(i), rsp_rdata);
        end
        {cfg_select_four_en, cfg_select_three_en, cfg_select_two_en} = 3'b000;
    endtask

    task automatic t_nibble();
        cfg_nibble_bus = 1'b1;
        access(1'b1, 1'b0, SEL_ONE, 22'h000123, 8'hE7, 99);
        check("nibble drive", 8'h0F, s_oe[3]);
        access(1'b0, 1'b0, SEL_ONE, 22'h000123, 8'h00, 99);
        check("nibble read data", 8'h07, rsp_rdata);
        cfg_nibble_bus = 1'b0;
    endtask

    task automatic t_dram();
        cfg_dram_en = 1'b1;
        access(1'b1, 1'b1, SEL_ONE, 22'h2D1ACE, 8'h96, 99);
        check("dram write latency", 7, lat);
        check("row address", 11'h5A3, s_low[2][10:0]);
        check("column address", 15'h02CE, s_low[5]);
        check("dram write pins", 5'b00101, s_pin[5][4:0]);
        check("dram idle strobes", 2'b11, s_pin[9][4:3]);
        access(1'b0, 1'b1, SEL_ONE, 22'h2D1ACE, 8'h00, 99);
        check("dram read latency", 7, lat);
        check("dram read pins", 5'b00110, s_pin[5][4:0]);
        check("dram read data", 8'h96, rsp_rdata);
        cfg_dram_en = 1'b0;
    endtask

    task automatic t_abort();
        access(1'b1, 1'b0, SEL_ONE, 22'h000200, 8'h11, 3);
        check("aborted response", 0, lat);
        check("aborted pins", 6'h3F, s_pin[6]);
        check("aborted drive", 8'h00, s_oe[6]);
    endtask

    task automatic hold(input logic [2:0] mode, input logic [5:0] exp);
        {sw_reset, indiv_reset, stop_mode} = mode;
        tick();
        tick();
        check("hold ready", 0, req_ready);
        check("hold low address", 15'h2345, mem_addr_low_bus);
        check("hold pins", exp, pins());
        check("hold drive", 8'h00, mem_data_bus_oe);
        {sw_reset, indiv_reset, stop_mode} = 3'b000;
        tick();
    endtask

    task automatic t_holds();
        access(1'b1, 1'b0, SEL_ONE, 22'h012345, 8'h5A, 99);
        hold(3'b010, 6'b010111);
        hold(3'b001, 6'b010111);
        cfg_dram_en = 1'b1;
        cfg_refresh_en = 1'b1;
        hold(3'b010, 6'b000111);
        hold(3'b001, 6'b011111);
        cfg_refresh_en = 1'b0;
        hold(3'b010, 6'b011111);
        cfg_dram_en = 1'b0;
        hold(3'b100, 6'b111111);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {sw_reset, indiv_reset, stop_mode, cfg_nibble_bus, cfg_dram_en, cfg_refresh_en} = 6'h00;
        {cfg_select_four_en, cfg_select_three_en, cfg_select_two_en, req_valid, req_write, req_dram} = 6'h00;
        {req_select, req_addr, req_wdata} = 32'h0;
        rst = 1'b1;
        repeat (10) @(posedge clock);
        #2;
        check("reset pins", 6'h3F, pins());
        check("reset low address", 15'h7FFF, mem_addr_low_bus);
        check("reset drive", 8'h00, mem_data_bus_oe);
        rst = 1'b0;
        tick();
        check("ready after reset", 1, req_ready);
        t_static();
        t_selects();
        t_nibble();
        t_dram();
        t_abort();
        t_holds();
        complete_run();
    end
endmodule

`default_nettype wire
